// ### inc/rssl_pkg.sv
// constants, field layouts and state type of the radio synthesizer serial loader
// assumes a 32-bit apb slave port and a 19-bit serial word with the latch select bit last
package rssl_pkg;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int SHIFT_W = 19;
  localparam int LATCH_SEL_POS = 0;
  localparam logic LATCH_SEL_REF = 1'b1;
  localparam int REF_CS_POS = 18;
  localparam int REF_LOCK_SEL_POS = 17;
  localparam int REF_PHASE_POL_POS = 16;
  localparam int REF_R_LSB = 1;
  localparam int REF_R_W = 14;
  localparam int PROG_N_LSB = 8;
  localparam int PROG_N_W = 11;
  localparam int PROG_A_LSB = 1;
  localparam int PROG_A_W = 7;

  // ----------------------------------------------------------------
  // pin synchroniser lanes
  // ----------------------------------------------------------------
  localparam int PIN_W = 7;
  localparam int PIN_CLK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_LOAD = 2;
  localparam int PIN_LOCK = 3;
  localparam int PIN_FMON = 4;
  localparam int PIN_TXN = 5;
  localparam int PIN_RXN = 6;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_REF = 12'h008;
  localparam logic [11:0] ADDR_PROG = 12'h00c;
  localparam logic [11:0] ADDR_SHIFT = 12'h010;
  localparam int CTRL_EN_POS = 0;
  localparam int ST_LOCK_POS = 0;
  localparam int ST_REF_POS = 1;
  localparam int ST_PROG_POS = 2;
  localparam int ST_RX_POS = 3;
  localparam int ST_TX_POS = 4;
  localparam logic CTRL_EN_RESET = 1'b1;

  // ----------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_prev;
    logic load_prev;
    logic [SHIFT_W-1:0] shift;
    logic [SHIFT_W-1:0] ref_word;
    logic [SHIFT_W-1:0] prog_word;
    logic enable;
    logic ref_loaded;
    logic prog_loaded;
    logic lock_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rssl_state_s;

endpackage

// ### rtl/rssl_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes each lane is an independent level; no lane relation is kept across the crossing
`timescale 1ns/1ns
`default_nettype none

module rssl_sync #(
  parameter int W = 1
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // synchronised levels
);

  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } rssl_sync_s;

  rssl_sync_s st;
  rssl_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule

`default_nettype wire

// ### rtl/rssl_top.sv
// serial loader of the radio synthesizer: three-wire link into a 19-bit shift register,
// latch transfer on load strobe, lock indicator output, apb view of latches and status
// assumes the link pins are asynchronous to pclk and change slowly compared with it
`timescale 1ns/1ns
`default_nettype none

module rssl_top (
  input wire logic pclk, // system clock, 10 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [rssl_pkg::APB_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic link_clk, // serial clock pin
  input wire logic link_data, // serial data pin
  input wire logic load_strobe, // load enable pin
  input wire logic synth_locked, // phase detector lock level
  input wire logic freq_monitor, // divided frequency monitor level
  input wire logic transmit_select_n, // transmit select pin, active low
  input wire logic receive_select_n, // receive select pin, active low
  output logic lock_indicator // lock indicator pin
);
  import rssl_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_s;

  rssl_sync #(.W(PIN_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({receive_select_n, transmit_select_n, freq_monitor, synth_locked, load_strobe, link_data, link_clk}),
    .q(pin_s)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_mapped(input logic [APB_ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_REF) ||
                  (a == ADDR_PROG) || (a == ADDR_SHIFT);
  endfunction

  function automatic logic [31:0] read_mux(input logic [APB_ADDR_W-1:0] a, input rssl_state_s s,
                                           input logic [PIN_W-1:0] p);
    read_mux = 32'h0;
    case (a)
      ADDR_CTRL: begin
        read_mux[CTRL_EN_POS] = s.enable;
      end
      ADDR_STATUS: begin
        read_mux[ST_LOCK_POS] = p[PIN_LOCK];
        read_mux[ST_REF_POS] = s.ref_loaded;
        read_mux[ST_PROG_POS] = s.prog_loaded;
        read_mux[ST_RX_POS] = ~p[PIN_RXN];
        read_mux[ST_TX_POS] = ~p[PIN_TXN];
      end
      ADDR_REF: begin
        read_mux[SHIFT_W-1:0] = s.ref_word;
      end
      ADDR_PROG: begin
        read_mux[SHIFT_W-1:0] = s.prog_word;
      end
      ADDR_SHIFT: begin
        read_mux[SHIFT_W-1:0] = s.shift;
      end
      default: begin
        read_mux = 32'h0;
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rssl_state_s st;
  rssl_state_s next_st;
  logic clk_rise;
  logic load_rise;
  logic apb_setup;
  logic apb_access;

  assign clk_rise = pin_s[PIN_CLK] & ~st.clk_prev;
  assign load_rise = pin_s[PIN_LOAD] & ~st.load_prev;
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable & st.pready;

  always_comb begin
    next_st = st;
    next_st.clk_prev = pin_s[PIN_CLK];
    next_st.load_prev = pin_s[PIN_LOAD];

    // register writes; clears come first so a same-cycle load sets the flag again
    if (apb_access && pwrite && !st.pslverr) begin
      case (paddr)
        ADDR_CTRL: begin
          next_st.enable = pwdata[CTRL_EN_POS];
        end
        ADDR_STATUS: begin
          if (pwdata[ST_REF_POS]) begin
            next_st.ref_loaded = 1'b0;
          end
          if (pwdata[ST_PROG_POS]) begin
            next_st.prog_loaded = 1'b0;
          end
        end
        default: begin
          next_st.enable = st.enable;
        end
      endcase
    end

    // serial shift, newest bit enters at the latch select position
    if (st.enable && clk_rise) begin
      next_st.shift = {st.shift[SHIFT_W-2:0], pin_s[PIN_DATA]};
    end

    // latch transfer chosen by the last bit received
    if (st.enable && load_rise) begin
      if (st.shift[LATCH_SEL_POS] == LATCH_SEL_REF) begin
        next_st.ref_word = st.shift;
        next_st.ref_loaded = 1'b1;
      end else begin
        next_st.prog_word = st.shift;
        next_st.prog_loaded = 1'b1;
      end
    end

    // pin shows lock unless the reference word selected the frequency monitor
    next_st.lock_out = st.ref_word[REF_LOCK_SEL_POS] ? pin_s[PIN_FMON] : pin_s[PIN_LOCK];

    // apb answer prepared in setup, presented during the access cycle
    next_st.pready = apb_setup;
    next_st.pslverr = apb_setup & ~addr_mapped(paddr);
    if (apb_setup) begin
      next_st.prdata = (!pwrite && addr_mapped(paddr)) ? read_mux(paddr, st, pin_s) : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.enable <= CTRL_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign lock_indicator = st.lock_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_shift_capture: assert property (
    st.enable && clk_rise |=>
      st.shift[0] == $past(pin_s[PIN_DATA]) && st.shift[SHIFT_W-1:1] == $past(st.shift[SHIFT_W-2:0])
  ) else $error("shift register missed a serial clock edge");

  a_shift_quiet: assert property (
    !clk_rise |=> $stable(st.shift)
  ) else $error("shift register moved without a serial clock edge");

  a_ref_select: assert property (
    st.enable && load_rise && st.shift[LATCH_SEL_POS] == LATCH_SEL_REF |=>
      st.ref_word == $past(st.shift) && $stable(st.prog_word) && st.ref_loaded
  ) else $error("reference word load went wrong");

  a_prog_select: assert property (
    st.enable && load_rise && st.shift[LATCH_SEL_POS] != LATCH_SEL_REF |=>
      st.prog_word == $past(st.shift) && $stable(st.ref_word) && st.prog_loaded
  ) else $error("programmable word load went wrong");

  a_latch_hold: assert property (
    !load_rise |=> $stable(st.ref_word) && $stable(st.prog_word)
  ) else $error("latch changed without a load strobe");

  a_lock_follow: assert property (
    !st.ref_word[REF_LOCK_SEL_POS] && pin_s[PIN_LOCK] |=> lock_indicator
  ) else $error("lock indicator low while locked");

  a_unlock_follow: assert property (
    !st.ref_word[REF_LOCK_SEL_POS] && !pin_s[PIN_LOCK] |=> !lock_indicator
  ) else $error("lock indicator high while unlocked");

  a_apb_answer: assert property (
    apb_setup |=> pready ##1 !pready
  ) else $error("apb answer not a single access cycle");

endmodule

`default_nettype wire

// ### verif/rssl_host_model.sv
// host side of the three-wire link: shifts a 19-bit word msb first, then pulses load enable
// assumes pclk at 10 MHz; a link half period is four pclk cycles, so the link clock runs at 800 ns
`timescale 1ns/1ns
`default_nettype none

module rssl_host_model (
  input wire logic pclk, // bench clock
  output logic link_clk, // serial clock, low between frames
  output logic link_data, // serial data
  output logic load_strobe // load enable
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    load_strobe = 1'b0;
  end

  task automatic send(input logic [18:0] w);
    for (int i = 18; i >= 0; i--) begin
      link_clk <= 1'b0;
      link_data <= w[i];
      repeat (4) @(posedge pclk);
      link_clk <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    link_clk <= 1'b0;
    link_data <= ~w[0]; // released line shows no stale bit
    repeat (6) @(posedge pclk);
    load_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    load_strobe <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// ### verif/rssl_top_tb_top.sv
// self-checking bench of the serial loader: apb master, host link model, integer reference model
// assumes rssl_top answers apb with one access cycle and rssl_host_model drives the link
`timescale 1ns/1ns
`default_nettype none

module rssl_top_tb_top;
  import rssl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, en;
  logic synth_locked, freq_monitor, transmit_select_n, receive_select_n, lock_indicator;
  logic link_clk, link_data, load_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [18:0] exp_ref, exp_prog, exp_shift;
  logic [2:0] exp_flags;
  logic [15:0] lfsr;
  int err_count, tests_run;
  // settling waits after a load or a mode switch, scaled down to keep the run short
  localparam int SETTLE_CYCLES = 40;

  rssl_top i_rssl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_clk(link_clk), .link_data(link_data), .load_strobe(load_strobe), .synth_locked(synth_locked),
    .freq_monitor(freq_monitor), .transmit_select_n(transmit_select_n),
    .receive_select_n(receive_select_n), .lock_indicator(lock_indicator));
  rssl_host_model i_rssl_host_model (.pclk(pclk), .link_clk(link_clk), .link_data(link_data),
    .load_strobe(load_strobe));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #2000000;
    err_count++;
    report_and_stop();
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [18:0] prog_word(input int ch);
    int n;
    n = (433075 + 25 * ch - 21700) / 25;
    return {11'(n / 64), 7'(n % 64), 1'b0};
  endfunction

  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'h0);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_all();
    apb(1'b0, ADDR_REF, 32'h0);
    chk(rd, 32'(exp_ref));
    apb(1'b0, ADDR_PROG, 32'h0);
    chk(rd, 32'(exp_prog));
    apb(1'b0, ADDR_SHIFT, 32'h0);
    chk(rd, 32'(exp_shift));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'({~transmit_select_n, ~receive_select_n, exp_flags[2:1], synth_locked}));
  endtask

  task automatic load(input logic [18:0] w);
    i_rssl_host_model.send(w);
    if (en) begin
      exp_shift = w;
      if (w[LATCH_SEL_POS] === LATCH_SEL_REF) begin
        exp_ref = w;
        exp_flags[1] = 1'b1;
      end else begin
        exp_prog = w;
        exp_flags[2] = 1'b1;
      end
    end
    repeat (SETTLE_CYCLES) @(posedge pclk);
    check_all();
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, synth_locked, en} = '0;
    {freq_monitor, transmit_select_n, receive_select_n} = 3'b111;
    {exp_ref, exp_prog, exp_shift, exp_flags} = '0;
    lfsr = 16'd45100;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    en = 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    check_all();
    receive_select_n <= 1'b0;
    load(prog_word(0));
    load({1'b0, 1'b0, 1'b1, 1'b0, 14'd850, LATCH_SEL_REF});
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      load(prog_word(int'(lfsr % 16'd69)));
    end
    apb(1'b1, ADDR_STATUS, 32'h6);
    exp_flags = 3'b000;
    check_all();
    apb(1'b1, ADDR_CTRL, 32'h0);
    en = 1'b0;
    load(prog_word(5));
    apb(1'b1, ADDR_CTRL, 32'h1);
    en = 1'b1;
    load(prog_word(68));
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rd, 32'h0);
    for (int k = 0; k < 6; k++) begin
      lfsr = lfsr_next(lfsr);
      synth_locked <= lfsr[0];
      freq_monitor <= ~lfsr[0];
      repeat (8) @(posedge pclk);
      chk(32'(lock_indicator), 32'(synth_locked));
    end
    receive_select_n <= 1'b1;
    transmit_select_n <= 1'b0;
    repeat (SETTLE_CYCLES) @(posedge pclk);
    check_all();
    transmit_select_n <= 1'b1;
    receive_select_n <= 1'b0;
    repeat (SETTLE_CYCLES) @(posedge pclk);
    check_all();
    // second reset in mid-run: latches and flags clear, enable back to its reset value
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {exp_ref, exp_prog, exp_shift, exp_flags} = '0;
    repeat (4) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    check_all();
    report_and_stop();
  end
endmodule

`default_nettype wire
